// ---- swr_ctrl.v ----
// Behaviour
// - logic clock is oscillator divided by divisor field, one to four
// - host interface logic is paced by host bus or serial clock
// - standby stops the oscillator and most internal logic
// - wake on bus activity, status read or power applied
// - wake interrupt raised when enabled and control logic powered
// - no wake interrupt when logic supply is switched by supply enable
// - all supplies: supply enable floats in standby, drives when active
// - unserviced bus-activity wake with all supplies returns to standby on its own
// - battery and transceiver only: bus activity turns supply enable on
// - battery only: ignore bus activity, float until logic supplies appear
// - inactive while reset pin low, active once it returns high
// - fifo contents discarded whenever reset is asserted
// - bus-activity wake with all supplies keeps the waking frame receivable
`timescale 1ns/1ns
`default_nettype none
`include "swr_defines.vh"

module swr_ctrl #(
  parameter [`SWR_CNT_W-1:0] WAKE_CYC = `SWR_WAKE_CYC
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_rst_n_pin,
  input wire i_vdd_present,
  input wire i_vcc_present,
  input wire i_int_enable,
  input wire i_cfg_load,
  input wire [`SWR_DIV_W-1:0] i_osc_div,
  input wire i_standby_cmd,
  input wire i_status_read,
  input wire i_int_ack,
  input wire i_bus_activity,
  input wire i_cs_n,
  input wire i_host_clk,
  output reg o_logic_tick,
  output reg o_host_edge,
  output reg o_active,
  output reg o_standby,
  output reg o_rx_enable,
  output reg o_fifo_clear,
  output reg o_supply_en_out,
  output reg o_supply_en_oe_n,
  output reg o_irq_out,
  output reg o_irq_oe_n,
  output reg o_cfg_settled
);

  localparam [2:0] ST_INACTIVE = 3'h0;
  localparam [2:0] ST_ACTIVE = 3'h1;
  localparam [2:0] ST_STANDBY = 3'h2;
  localparam [2:0] ST_WAKE = 3'h3;
  localparam [2:0] ST_PWRUP = 3'h4;
  localparam [`SWR_CNT_W-1:0] TCON_CYC = `SWR_TCON_CYC;

  reg rst_meta_reg;
  reg rst_sync_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`SWR_DIV_W-1:0] div_reg;
  reg [`SWR_CNT_W-1:0] wake_cnt_reg;
  reg [`SWR_CNT_W-1:0] tcon_cnt_reg;
  reg tcon_run_reg;
  reg power_q_reg;
  reg host_clk_q_reg;
  wire dev_rst;
  wire power_ok;
  wire power_rise;
  wire div_tick;
  wire timeout;

  // pin is async to us; only the second flop is used downstream
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= i_rst_n_pin;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign dev_rst = i_rst | ~rst_sync_reg;
  assign power_ok = i_vdd_present & i_vcc_present;
  assign power_rise = power_ok & ~power_q_reg;
  assign timeout = (wake_cnt_reg >= WAKE_CYC);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_INACTIVE: begin
        if (power_ok) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (i_standby_cmd) begin
          state_next = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (power_rise || (power_ok && i_status_read)) begin
          state_next = ST_ACTIVE;
        end else if (power_ok && i_bus_activity) begin
          state_next = ST_WAKE;
        end else if (i_vcc_present && !i_vdd_present && i_bus_activity) begin
          state_next = ST_PWRUP;
        end
      end
      ST_WAKE: begin
        if (i_int_ack || i_status_read) begin
          state_next = ST_ACTIVE;
        end else if (timeout) begin
          state_next = ST_STANDBY;
        end
      end
      ST_PWRUP: begin
        // logic supply now follows supply enable; no interrupt path here
        if (power_ok) begin
          state_next = ST_ACTIVE;
        end
      end
      default: begin
        state_next = ST_INACTIVE;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (dev_rst) begin
      state_reg <= ST_INACTIVE;
      power_q_reg <= 1'b0;
      wake_cnt_reg <= {`SWR_CNT_W{1'b0}};
    end else begin
      state_reg <= state_next;
      power_q_reg <= power_ok;
      if (state_reg == ST_WAKE) begin
        wake_cnt_reg <= wake_cnt_reg + 16'h0001;
      end else begin
        wake_cnt_reg <= {`SWR_CNT_W{1'b0}};
      end
    end
  end

  // divisor and settling timer
  always @(posedge i_ref_clk) begin
    if (dev_rst) begin
      div_reg <= `SWR_DIV_RST;
      tcon_cnt_reg <= {`SWR_CNT_W{1'b0}};
      tcon_run_reg <= 1'b0;
      o_cfg_settled <= 1'b0;
    end else if (i_cfg_load && state_reg == ST_ACTIVE) begin
      div_reg <= i_osc_div;
      tcon_cnt_reg <= {`SWR_CNT_W{1'b0}};
      tcon_run_reg <= 1'b1;
      o_cfg_settled <= 1'b0;
    end else if (tcon_run_reg) begin
      tcon_cnt_reg <= tcon_cnt_reg + 16'h0001;
      if (tcon_cnt_reg + 16'h0001 >= TCON_CYC) begin
        tcon_run_reg <= 1'b0;
        o_cfg_settled <= 1'b1;
      end
    end
  end

  // divider halts in standby; restarts at once on a wake so the frame is caught
  swr_clk_div u_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(dev_rst),
    .i_run(state_next == ST_ACTIVE || state_next == ST_WAKE),
    .i_div(div_reg),
    .o_tick(div_tick)
  );

  // host clock sampled at 20 MHz; fine up to the host's 4.2 MHz limit
  always @(posedge i_ref_clk) begin
    if (dev_rst) begin
      host_clk_q_reg <= 1'b0;
      o_host_edge <= 1'b0;
    end else begin
      host_clk_q_reg <= i_host_clk;
      o_host_edge <= i_host_clk & ~host_clk_q_reg & ~i_cs_n & (state_reg == ST_ACTIVE);
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_logic_tick <= 1'b0;
      o_active <= 1'b0;
      o_standby <= 1'b0;
      o_rx_enable <= 1'b0;
      o_fifo_clear <= 1'b1;
      o_supply_en_out <= 1'b0;
      o_supply_en_oe_n <= 1'b1;
      o_irq_out <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end else begin
      o_logic_tick <= div_tick;
      o_active <= (state_reg == ST_ACTIVE);
      o_standby <= (state_reg == ST_STANDBY);
      o_rx_enable <= (state_reg == ST_ACTIVE) || (state_reg == ST_WAKE);
      o_fifo_clear <= dev_rst;
      o_supply_en_out <= 1'b1;
      // floats in standby and while held inactive
      o_supply_en_oe_n <= ~((state_reg == ST_ACTIVE) || (state_reg == ST_WAKE)
                            || (state_reg == ST_PWRUP));
      o_irq_out <= 1'b0;
      o_irq_oe_n <= ~((state_reg == ST_WAKE) && i_int_enable && i_vdd_present);
    end
  end

endmodule
`default_nettype wire

// ---- swr_defines.vh ----
`ifndef SWR_DEFINES_VH
`define SWR_DEFINES_VH

// reference clock rate
`define SWR_CLK_MHZ 20
// oscillator divisor field: code 0..3 selects divide by 1..4
`define SWR_DIV_W 2
`define SWR_DIV_RST 2'h0
// configuration settling interval
`define SWR_TCON_NS 10000
`define SWR_TCON_CYC ((`SWR_TCON_NS * `SWR_CLK_MHZ) / 1000)
// unserviced wake-up timeout before falling back to standby
`define SWR_WAKE_US 1000
`define SWR_WAKE_CYC (`SWR_WAKE_US * `SWR_CLK_MHZ)
`define SWR_CNT_W 16

`endif

// ---- swr_clk_div.v ----
`timescale 1ns/1ns
`default_nettype none
`include "swr_defines.vh"

module swr_clk_div (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_run,
  input wire [`SWR_DIV_W-1:0] i_div,
  output reg o_tick
);

  reg [`SWR_DIV_W-1:0] cnt_reg;

  always @(posedge i_ref_clk) begin
    if (i_rst || !i_run) begin
      cnt_reg <= {`SWR_DIV_W{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt_reg >= i_div) begin
      cnt_reg <= {`SWR_DIV_W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- swr_ctrl_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module swr_ctrl_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_rst_n_pin,
  input wire logic i_vdd_present,
  input wire logic i_vcc_present,
  input wire logic i_int_enable,
  input wire logic i_standby_cmd,
  input wire logic i_bus_activity,
  input wire logic o_active,
  input wire logic o_standby,
  input wire logic o_rx_enable,
  input wire logic o_fifo_clear,
  input wire logic o_supply_en_oe_n,
  input wire logic o_irq_oe_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_fifo_drop: assert property (!i_rst_n_pin |-> ##[1:4] o_fifo_clear) else $error("fifo kept");
  chk_pin_hold: assert property (!i_rst_n_pin [*5] |-> !o_active) else $error("active in reset");
  chk_sync_release: assert property ($rose(i_rst_n_pin) |-> !o_active ##1 !o_active) else $error("no sync");
  chk_standby_float: assert property (o_standby |-> o_supply_en_oe_n) else $error("supply driven");
  chk_wake_drive: assert property (o_standby && i_bus_activity && i_vcc_present |-> ##2 !o_supply_en_oe_n)
    else $error("no supply on wake");
  chk_wake_irq: assert property (o_standby && i_bus_activity && i_vcc_present && i_vdd_present && i_int_enable
    |-> ##2 (!o_irq_oe_n && o_rx_enable)) else $error("no wake irq");
  chk_no_irq: assert property (!i_vdd_present [*3] |-> o_irq_oe_n) else $error("irq unpowered");
  chk_batt_only: assert property (o_standby && !i_vcc_present && !i_vdd_present |=> o_standby)
    else $error("woke on battery");
  chk_cmd_sleep: assert property (o_active && i_standby_cmd |-> ##2 o_standby) else $error("no standby");
endmodule
bind swr_ctrl swr_ctrl_chk u_chk (.*);
`default_nettype wire

// ---- swr_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module swr_host_model (
  input wire logic i_ref_clk,
  input wire logic i_go,
  output logic o_cs_n,
  output logic o_host_clk
);
  logic [4:0] cnt_reg = 5'h00;
  always @(posedge i_ref_clk) begin
    if (cnt_reg != 5'h00)
      cnt_reg <= (cnt_reg == 5'h1A) ? 5'h00 : cnt_reg + 5'h01;
    else if (i_go)
      cnt_reg <= 5'h01;
  end
  // four clocks near 3.3 MHz, low outside the frame
  assign o_cs_n = (cnt_reg == 5'h00);
  assign o_host_clk = (cnt_reg < 5'h18) && (cnt_reg % 6 >= 3);
endmodule
`default_nettype wire

// ---- standby_wake_reset_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module standby_wake_reset_control_bench;
  logic i_ref_clk, i_rst, i_rst_n_pin, i_vdd_present, i_vcc_present, i_int_enable, go;
  logic i_cfg_load, i_standby_cmd, i_status_read, i_int_ack, i_bus_activity;
  logic [1:0] i_osc_div;
  wire i_cs_n, i_host_clk, o_logic_tick, o_host_edge, o_active, o_standby, o_rx_enable, o_fifo_clear;
  wire o_supply_en_out, o_supply_en_oe_n, o_irq_out, o_irq_oe_n, o_cfg_settled;
  int err_count = 0;
  int check_count = 0;
  int edges = 0;
  logic [31:0] seed = 32'h4EDF4427;
  // small timeout keeps the unserviced wake short
  swr_ctrl #(.WAKE_CYC(16'h0014)) u_swr_ctrl (.*);
  swr_host_model u_swr_host_model (.i_ref_clk(i_ref_clk), .i_go(go), .o_cs_n(i_cs_n), .o_host_clk(i_host_clk));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function int exp_period(logic [1:0] c);
    return c + 1;
  endfunction
  task tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t bit mismatch", $time);
    end
  endtask
  task chk_n(int got, int lo, int hi);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %0t count %0d", $time, got);
    end
  endtask
  task tick_n(int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task pulse(input int k);
    @(posedge i_ref_clk);
    case (k)
      0: i_cfg_load <= 1'h1;
      1: i_standby_cmd <= 1'h1;
      2: i_status_read <= 1'h1;
      3: i_bus_activity <= 1'h1;
      default: i_int_ack <= 1'h1;
    endcase
    @(posedge i_ref_clk);
    {i_cfg_load, i_standby_cmd, i_status_read, i_bus_activity, i_int_ack} <= 5'h00;
  endtask
  task wait_act();
    int i;
    for (i = 0; i < 20 && o_active !== 1'b1; i++) tick_n(1);
    chk(o_active, 1'b1);
  endtask
  always @(posedge i_ref_clk) if (o_host_edge === 1'b1) edges++;
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    int i, n;
    logic [31:0] r;
    logic [1:0] c;
    {i_rst, i_rst_n_pin, i_vdd_present, i_vcc_present, i_int_enable} = 5'h1F;
    {i_cfg_load, i_standby_cmd, i_status_read, i_int_ack, i_bus_activity, go} = 6'h00;
    i_osc_div = 2'h0;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    wait_act();
    chk(o_fifo_clear, 1'b0);
    for (i = 0; i < 4; i++) begin
      r = xs();
      c = i[1:0] ^ r[1:0];
      @(posedge i_ref_clk) i_osc_div <= c;
      pulse(0);
      tick_n(8);
      for (n = 0; n < 20 && o_logic_tick !== 1'b1; n++) tick_n(1);
      n = 0;
      do begin tick_n(1); n++; end while (o_logic_tick !== 1'b1 && n < 20);
      chk_n(n, exp_period(c), exp_period(c));
    end
    pulse(0);
    for (n = 0; n < 400 && o_cfg_settled !== 1'b1; n++) tick_n(1);
    chk_n(n, 195, 202);
    $display("clock tests done");
    @(posedge i_ref_clk) go <= 1'h1;
    @(posedge i_ref_clk) go <= 1'h0;
    tick_n(32);
    chk_n(edges, 4, 4);
    pulse(1);
    tick_n(3);
    chk(o_standby, 1'b1);
    chk(o_supply_en_oe_n, 1'b1);
    pulse(3);
    tick_n(2);
    chk(o_rx_enable, 1'b1);
    chk(o_supply_en_oe_n, 1'b0);
    chk(o_irq_oe_n, 1'b0);
    chk(o_supply_en_out, 1'b1);
    chk(o_irq_out, 1'b0);
    tick_n(30);
    chk(o_standby, 1'b1);
    pulse(2);
    tick_n(3);
    chk(o_standby, 1'b0);
    @(posedge i_ref_clk) i_int_enable <= 1'h0;
    pulse(1);
    tick_n(3);
    pulse(3);
    tick_n(2);
    chk(o_irq_oe_n, 1'b1);
    chk(o_rx_enable, 1'b1);
    @(posedge i_ref_clk) i_int_enable <= 1'h1;
    pulse(4);
    tick_n(3);
    chk(o_active, 1'b1);
    $display("wake tests done");
    @(posedge i_ref_clk) i_rst_n_pin <= 1'h0;
    tick_n(5);
    chk(o_fifo_clear, 1'b1);
    chk(o_active, 1'b0);
    @(posedge i_ref_clk) i_rst_n_pin <= 1'h1;
    tick_n(1);
    chk(o_active, 1'b0);
    wait_act();
    pulse(1);
    tick_n(3);
    @(posedge i_ref_clk) i_vdd_present <= 1'h0;
    pulse(3);
    tick_n(3);
    chk(o_supply_en_oe_n, 1'b0);
    chk(o_irq_oe_n, 1'b1);
    @(posedge i_ref_clk) i_vdd_present <= 1'h1;
    wait_act();
    pulse(1);
    tick_n(3);
    @(posedge i_ref_clk) {i_vdd_present, i_vcc_present} <= 2'h0;
    pulse(3);
    tick_n(3);
    chk(o_standby, 1'b1);
    chk(o_supply_en_oe_n, 1'b1);
    @(posedge i_ref_clk) {i_vdd_present, i_vcc_present} <= 2'h3;
    tick_n(3);
    chk(o_standby, 1'b0);
    $display("supply tests done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
